// ---- hdl/bsl_pkg.sv ----
// bsl_pkg: shared constants and carriers for the boot strap latch
// assumes: nothing; used by bsl_boot_strap_latch and tb
package bsl_pkg;

    localparam int unsigned STRAP_COUNT = 3;
    localparam int unsigned STRAP_IDX_FIRST = 0;
    localparam int unsigned STRAP_IDX_SECOND = 1;
    localparam int unsigned STRAP_IDX_THIRD = 2;
    localparam logic [2:0] STRAP_RESET_VALUE = 3'h4; // third strap pulled up
    localparam logic [1:0] POLICY_ALWAYS_ON = 2'h0;
    localparam logic [1:0] POLICY_LOW_ON = 2'h1;
    localparam logic [1:0] POLICY_HIGH_ON = 2'h2;
    localparam logic [1:0] POLICY_ALWAYS_OFF = 2'h3;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned HOLD_TIME_MS = 3;
    localparam int unsigned HOLD_CYCLES = (HOLD_TIME_MS * 1000000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        BSL_BOOT_FLASH,
        BSL_BOOT_DOWNLOAD,
        BSL_BOOT_UNDEFINED
    } bsl_boot_e;

    typedef struct packed {
        logic [2:0] bits;
        logic valid;
        logic invalid_combo;
    } bsl_strap_s;

endpackage

// ---- hdl/bsl_sync3.sv ----
// bsl_sync3: three-flop synchroniser for pin levels, one per bit
// assumes: inputs asynchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module bsl_sync3 #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] stable
);
    // one bit at least, or there is nothing to synchronise
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // first flop feeds only the second
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            meta_r <= async_in;
            s2_r <= meta_r;
            s3_r <= s2_r;
        end
    end

    // a level counts once the second and third flops agree
    assign sync_out = s3_r;
    assign stable = ~(s2_r ^ s3_r);
endmodule
`default_nettype wire

// ---- hdl/bsl_boot_strap_latch.sv ----
// bsl_boot_strap_latch: captures three strap pins in the hold window after reset release, decodes boot mode
// assumes: reset_n is the chip system reset (any cause); chip-enable low arrives separately on chip_en
`timescale 1ns/1ns
`default_nettype none
module bsl_boot_strap_latch #(
    parameter int unsigned HOLD_CYCLES = bsl_pkg::HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic chip_en,
    input wire logic strap_pin_first,
    input wire logic strap_pin_second,
    input wire logic strap_pin_third,
    input wire logic strap_pin_third_oe_n,
    input wire logic [1:0] print_policy,
    output logic [2:0] strap_value,
    output logic strap_valid,
    output logic pins_released,
    output logic third_pull_up_en,
    output bsl_pkg::bsl_boot_e boot_mode,
    output logic print_enable,
    output logic strap_invalid
);

    // a zero-length window would release the pins before any sample is taken
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin conditioning

    logic rst_n;
    logic [2:0] pin_level;
    logic [2:0] pin_sync;
    logic [2:0] pin_stable;
    bsl_pkg::bsl_strap_s strap_r;
    logic [31:0] hold_cnt_r;
    logic released_r;

    // chip enable low acts as a full reset, same as any other cause
    assign rst_n = reset_n & chip_en;

    // a floating third pin reads high through the internal pull-up
    assign pin_level = {strap_pin_third | strap_pin_third_oe_n,
                        strap_pin_second, strap_pin_first};

    bsl_sync3 #(
        .WIDTH(bsl_pkg::STRAP_COUNT),
        .INIT(bsl_pkg::STRAP_RESET_VALUE)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(rst_n),
        .async_in(pin_level),
        .sync_out(pin_sync),
        .stable(pin_stable)
    );

    ////////////////////////////////////////////////////////////////////////
    // capture window: sample until the hold time after reset release ends

    // counts the hold window; pins stay in strap duty until it runs out
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= 32'h0;
            released_r <= 1'b0;
        end else if (!released_r) begin
            if (hold_cnt_r >= HOLD_CYCLES - 1) begin
                released_r <= 1'b1;
            end
            hold_cnt_r <= hold_cnt_r + 32'h1;
        end
    end

    // latch tracks settled pin levels only while the window is open
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_r.bits <= bsl_pkg::STRAP_RESET_VALUE;
            strap_r.valid <= 1'b0;
            strap_r.invalid_combo <= 1'b0;
        end else if (!released_r) begin
            if (&pin_stable) begin
                strap_r.bits <= pin_sync;
            end
        end else if (!strap_r.valid) begin
            // freeze: from here on the pins are ordinary I/O
            strap_r.valid <= 1'b1;
            strap_r.invalid_combo <= ~strap_r.bits[bsl_pkg::STRAP_IDX_SECOND] &
                                     ~strap_r.bits[bsl_pkg::STRAP_IDX_THIRD];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic s_first;
    logic s_second;
    logic s_third;
    assign s_first = strap_r.bits[bsl_pkg::STRAP_IDX_FIRST];
    assign s_second = strap_r.bits[bsl_pkg::STRAP_IDX_SECOND];
    assign s_third = strap_r.bits[bsl_pkg::STRAP_IDX_THIRD];

    // boot mode; second and third both low fall back to flash with the flag raised, other unlisted combos decode undefined
    always_comb begin
        if (s_first && s_third) begin
            boot_mode = bsl_pkg::BSL_BOOT_FLASH;
        end else if (s_first && s_second && !s_third) begin
            boot_mode = bsl_pkg::BSL_BOOT_DOWNLOAD;
        end else if (!s_second && !s_third) begin
            boot_mode = bsl_pkg::BSL_BOOT_FLASH;
        end else begin
            boot_mode = bsl_pkg::BSL_BOOT_UNDEFINED;
        end
    end

    // print gating from the fuse policy field and the second strap
    always_comb begin
        unique case (print_policy)
            bsl_pkg::POLICY_ALWAYS_ON: print_enable = 1'b1;
            bsl_pkg::POLICY_LOW_ON: print_enable = ~s_second;
            bsl_pkg::POLICY_HIGH_ON: print_enable = s_second;
            bsl_pkg::POLICY_ALWAYS_OFF: print_enable = 1'b0;
        endcase
    end

    assign strap_value = strap_r.bits;
    assign strap_valid = strap_r.valid;
    assign strap_invalid = strap_r.invalid_combo;
    assign pins_released = released_r;
    assign third_pull_up_en = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [2:0] held_bits_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_bits_r <= bsl_pkg::STRAP_RESET_VALUE;
        end else begin
            held_bits_r <= strap_r.bits;
        end
    end

    chk_latch_holds_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid |-> strap_value == held_bits_r)
        else $error("strap bits changed after the capture window");
    chk_valid_after_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(pins_released) |=> $rose(strap_valid))
        else $error("strap not frozen one cycle after release");
    chk_valid_needs_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid |-> pins_released)
        else $error("strap valid before pin release");
    chk_flash_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_first && s_third) |-> boot_mode == bsl_pkg::BSL_BOOT_FLASH)
        else $error("flash boot not decoded");
    chk_download_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (strap_value == 3'h3) |-> boot_mode == bsl_pkg::BSL_BOOT_DOWNLOAD)
        else $error("download boot not decoded");
    chk_print_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (print_policy == 2'h0 |-> print_enable) and (print_policy == 2'h3 |-> !print_enable))
        else $error("fixed print policy ignored");
    chk_print_strapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (print_policy == 2'h1) |-> print_enable == !s_second)
        else $error("policy one print gating wrong");
    chk_invalid_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(strap_valid) |-> strap_invalid == (strap_value[2:1] == 2'h0))
        else $error("invalid strap combo not flagged");
    chk_release_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(pins_released) |-> hold_cnt_r == HOLD_CYCLES)
        else $error("pins released at wrong time");

    // latch clears in reset, tracks the pins in the window and freezes after it
    chk_reset_clears: assert property (@(posedge ref_clk)
        !rst_n |=> !strap_valid && !pins_released && !strap_invalid &&
            strap_value == bsl_pkg::STRAP_RESET_VALUE)
        else $error("latch not cleared by reset");
    chk_capture_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!released_r && (&pin_stable)) |=> strap_value == $past(pin_sync))
        else $error("settled pin level not captured in the window");
    chk_freeze_on_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pins_released |=> $stable(strap_value))
        else $error("strap bits moved after pin release");
    chk_released_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pins_released |=> pins_released)
        else $error("pins taken back before the next reset");
    chk_invalid_stands: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid |=> $stable(strap_invalid))
        else $error("invalid flag moved after freeze");
    chk_hold_count_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold_cnt_r <= HOLD_CYCLES)
        else $error("hold counter ran past the window");

    // the pair that must never be strapped: flag and fallback decode
    chk_invalid_needs_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_invalid |-> !strap_value[bsl_pkg::STRAP_IDX_SECOND] &&
            !strap_value[bsl_pkg::STRAP_IDX_THIRD])
        else $error("invalid flag raised for a legal combination");
    chk_invalid_after_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pins_released |-> !strap_invalid)
        else $error("invalid flag raised inside the window");
    chk_invalid_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!s_second && !s_third) |-> boot_mode == bsl_pkg::BSL_BOOT_FLASH)
        else $error("invalid combination not decoded as flash");

    // print gating with the strap-controlled polarity
    chk_print_inverted: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (print_policy == bsl_pkg::POLICY_HIGH_ON) |-> print_enable == s_second)
        else $error("policy two print gating wrong");
endmodule
`default_nettype wire

// ---- test/bsl_strap_host.sv ----
// bsl_strap_host: pull resistors or host outputs on the three strap pins
// assumes: tb sets levels early; wiggle is raised only after pins are released
`timescale 1ns/1ns
`default_nettype none
module bsl_strap_host (
    input wire logic ref_clk,
    input wire logic [2:0] level,
    input wire logic float_third,
    input wire logic wiggle,
    input wire logic pins_released,
    output logic [2:0] pins,
    output logic third_oe_n
);
    logic [2:0] drv_r;
    // levels held from power-up; toggling every cycle is normal pin use later
    always_ff @(posedge ref_clk) begin
        drv_r <= (wiggle && pins_released) ? ~drv_r : level;
    end
    // an undriven third pin reads high through the pull-up, never stale
    assign pins = {float_third ? 1'b1 : drv_r[2], drv_r[1:0]};
    assign third_oe_n = float_third;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// tb: boots the strap latch under many pin patterns and judges decode
// assumes: design assertions run inside; HOLD_CYCLES shortened to 16
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic chip_en = 1'b1;
    logic [2:0] level = 3'h5;
    logic float_third = 1'b0;
    logic wiggle = 1'b0;
    logic [1:0] print_policy = 2'h0;
    logic [2:0] pins;
    logic [2:0] strap_value;
    logic oe_n, strap_valid, pins_released, pull_en, print_enable, strap_invalid;
    bsl_pkg::bsl_boot_e boot_mode;
    int err_count = 0;
    int checks_done = 0;
    // shortened hold window so a boot takes some twenty cycles
    localparam int HOLD_LEN = 16;
    //////////////////////////////////////////////////////////////////////
    // clock, far side and design
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    bsl_strap_host i_bsl_strap_host (.ref_clk(ref_clk), .level(level),
        .float_third(float_third), .wiggle(wiggle), .pins_released(pins_released),
        .pins(pins), .third_oe_n(oe_n));
    bsl_boot_strap_latch #(.HOLD_CYCLES(HOLD_LEN)) i_bsl_boot_strap_latch (.ref_clk(ref_clk),
        .reset_n(reset_n), .chip_en(chip_en), .strap_pin_first(pins[0]),
        .strap_pin_second(pins[1]), .strap_pin_third(pins[2]),
        .strap_pin_third_oe_n(oe_n), .print_policy(print_policy),
        .strap_value(strap_value), .strap_valid(strap_valid),
        .pins_released(pins_released), .third_pull_up_en(pull_en),
        .boot_mode(boot_mode), .print_enable(print_enable), .strap_invalid(strap_invalid));
    //////////////////////////////////////////////////////////////////////
    // comparisons and expectations
    task automatic bad(input string msg);
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask
    task automatic cmp_bits(input logic [2:0] got, input logic [2:0] exp);
        checks_done++;
        if (got !== exp) bad("strap bits differ");
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) bad("flag differs");
    endtask
    task automatic cmp_mode(input bsl_pkg::bsl_boot_e got, input bsl_pkg::bsl_boot_e exp);
        checks_done++;
        if (got !== exp) bad("boot mode differs");
    endtask
    task automatic cmp_count(input int got, input int exp);
        checks_done++;
        if (got != exp) bad("cycle count differs");
    endtask
    // invalid pairs fall back to flash boot by the designer's choice
    function automatic bsl_pkg::bsl_boot_e exp_mode(input logic [2:0] v);
        if (v[0] && v[2]) return bsl_pkg::BSL_BOOT_FLASH;
        if (v == 3'h3) return bsl_pkg::BSL_BOOT_DOWNLOAD;
        if (!v[1] && !v[2]) return bsl_pkg::BSL_BOOT_FLASH;
        return bsl_pkg::BSL_BOOT_UNDEFINED;
    endfunction
    function automatic logic exp_print(input logic [1:0] p, input logic s);
        return (p == 2'h0) || (p == 2'h1 && !s) || (p == 2'h2 && s);
    endfunction
    task automatic judge(input logic [2:0] v);
        cmp_bits(strap_value, v);
        cmp_mode(boot_mode, exp_mode(v));
        cmp_bit(strap_invalid, !v[1] && !v[2]);
    endtask
    // every reset cause reaches the block as reset_n, chip enable separately
    task automatic boot(input logic [2:0] lv, input logic fl, input logic by_en);
        int n;
        @(posedge ref_clk);
        level <= lv;
        float_third <= fl;
        wiggle <= 1'b0;
        if (by_en) chip_en <= 1'b0;
        else reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        cmp_bits(strap_value, bsl_pkg::STRAP_RESET_VALUE);
        cmp_bit(strap_valid, 1'b0);
        cmp_bit(pins_released, 1'b0);
        @(posedge ref_clk);
        chip_en <= 1'b1;
        reset_n <= 1'b1;
        n = 0;
        while (pins_released !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp_count(n, HOLD_LEN);
        cmp_bit(strap_valid, 1'b0);
        @(posedge ref_clk);
        #1;
        cmp_bit(strap_valid, 1'b1);
    endtask
    //////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_modes();
        logic [2:0] tbl[6] = '{3'h5, 3'h3, 3'h1, 3'h2, 3'h7, 3'h4};
        foreach (tbl[i]) begin
            boot(tbl[i], 1'b0, 1'b0);
            judge(tbl[i]);
        end
    endtask
    task automatic t_float();
        boot(3'h3, 1'b1, 1'b0);
        judge(3'h7);
        cmp_bit(pull_en, 1'b1);
    endtask
    task automatic t_ignore();
        boot(3'h5, 1'b0, 1'b0);
        @(posedge ref_clk);
        wiggle <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        judge(3'h5);
    endtask
    task automatic t_print(input logic [2:0] v);
        boot(v, 1'b0, 1'b0);
        for (int p = 0; p < 4; p++) begin
            @(posedge ref_clk);
            print_policy <= 2'(p);
            @(posedge ref_clk);
            #1;
            cmp_bit(print_enable, exp_print(2'(p), v[1]));
        end
    endtask
    task automatic t_chip_en();
        boot(3'h5, 1'b0, 1'b0);
        boot(3'h3, 1'b0, 1'b1);
        judge(3'h3);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_modes();
        t_float();
        t_ignore();
        t_print(3'h5);
        t_print(3'h7);
        t_chip_en();
        conclude();
    end
    // the whole run needs some 280 cycles; far beyond that it has hung
    initial begin
        #40000;
        bad("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
